// ### ssw_watchdog.sv
/*
  self-supervision watchdog: restarts a stuck controller, latches a permanent fault,
  groups diagnostic sources, drives the fail-safe service output and diagnostic words.
  assumes all inputs synchronous to clk; diagnostic words are read straight off ports.
*/
// Notes on behaviour
// - missing kick from controller triggers a restart pulse, independent of its program.
// - restarts exhausted without recovery raise the permanent fault signal.
// - permanent fault blocks all digital outputs except the service output.
// - service output energized only with supply present and device fully operational.
// - internal supply voltage faults are supervised alongside program execution.
// - link and group alarms are routable to outputs via the output matrix.
// - each diagnostic source belongs to at most one of three groups (select value 3 is none); group is any member.
// - each group has a link to the service output; reset links group two only.
// - each group drives any selected output through its own matrix column.
// - boot self-test result gates operation; runtime checks continue afterward.
// - entering permanent state drops service output, lights indicator, raises panel fault.
// - permanent state is entered when main functions can no longer be handled.
// - temporary fault sets the group matrix signal and pulses the diagnostic-on event.
// - clearing of a temporary fault pulses the diagnostic-off event, unless another source rises in the same cycle.
// - front panel reset command clears the latched diagnostic state.
// - diagnostic words are sixteen bits wide and readable remotely.
// - first word: bits 0-1 reserved, 2-9 outputs 1-8, 10-14 aux 1-5, 15 output 9.
// - second word: bits 0-14 flag outputs ten to twenty-four.
// - fourth word bits 0-4: voltage, bus buffer, order code, option card, logic config.
// - fourth word bits 5-9: arc unit, arc sensor, storage card, arc input, low supply.
// - events carry the short code of the diagnostic bit that changed.
`timescale 1ns/1ps
`include "ssw_regs.svh"
module ssw_watchdog #(
  parameter int KICK_TIMEOUT_CYC = `SSW_KICK_TIMEOUT_US * `SSW_CLK_MHZ,
  parameter int RESTART_CYC      = `SSW_RESTART_US * `SSW_CLK_MHZ,
  parameter int RETRIES          = `SSW_RETRIES,
  parameter int OUT_N            = `SSW_OUT_N
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          mcu_kick,
  input  wire logic                          mcu_main_fail,
  input  wire logic                          boot_test_done,
  input  wire logic                          boot_test_pass,
  input  wire logic                          aux_supply_ok,
  input  wire logic                          panel_reset,
  input  wire logic                          remote_comm_inactive,
  input  wire logic                          ext_io_inactive,
  input  wire logic                          port1_down,
  input  wire logic                          port2_down,
  input  wire logic [23:0]                   out_channel_fault,
  input  wire logic [4:0]                    aux_channel_fault,
  input  wire logic [`SSW_PLAT_N-1:0]        platform_fault,
  input  wire logic [2*`SSW_SRC_N-1:0]       group_select,
  input  wire logic [`SSW_GRP_N-1:0]         service_link_set,
  input  wire logic                          service_link_we,
  input  wire logic [OUT_N-1:0]              matrix_col [8],
  input  wire logic [OUT_N-1:0]              logic_outputs,
  output logic      [OUT_N-1:0]              digital_outputs,
  output logic                               service_fail_output,
  output logic                               mcu_restart,
  output logic                               permanent_fault,
  output logic                               status_led,
  output logic                               panel_fault_msg,
  output logic      [`SSW_GRP_N-1:0]         fault_group,
  output logic                               diag_on_event,
  output logic                               diag_off_event,
  output logic      [3:0]                    diag_event_code,
  output logic      [`SSW_WORD_W-1:0]        output_fault_status_low,
  output logic      [`SSW_WORD_W-1:0]        output_fault_status_high,
  output logic      [`SSW_WORD_W-1:0]        platform_fault_status
);
  typedef struct packed {
    ssw_pkg::ssw_state_type     st;
    logic [31:0]                cnt;
    logic [7:0]                 tries;
    logic [`SSW_GRP_N-1:0]      link;
    logic [`SSW_GRP_N-1:0]      grp_latch;
    logic [`SSW_SRC_N-1:0]      prev_src;
    logic [OUT_N-1:0]           dout;
    logic                       sf;
    logic                       on_ev;
    logic                       off_ev;
    logic [3:0]                 code;
    logic [`SSW_WORD_W-1:0]     w_lo;
    logic [`SSW_WORD_W-1:0]     w_hi;
    logic [`SSW_WORD_W-1:0]     w_pl;
  } ssw_core_type;

  ssw_core_type q, d;
  logic [`SSW_SRC_N-1:0] src;
  logic [`SSW_GRP_N-1:0] grp_now;
  logic [`SSW_SRC_N-1:0] rise, fall;

  // first changed source index, used as the event short code
  function automatic logic [3:0] first_set(input logic [`SSW_SRC_N-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `SSW_SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // platform faults are the group sources; low supply and voltage faults included
  assign src = platform_fault;
  assign rise = src & ~q.prev_src;
  assign fall = ~src & q.prev_src;

  genvar g;
  generate
    for (g = 0; g < `SSW_GRP_N; g++) begin : grp_gen
      logic [`SSW_SRC_N-1:0] member;
      for (genvar s = 0; s < `SSW_SRC_N; s++) begin : src_gen
        assign member[s] = (group_select[2*s +: 2] == 2'(g)) & src[s];
      end
      assign grp_now[g] = |member;
    end
  endgenerate

  always_comb begin
    logic [OUT_N-1:0] routed;
    logic [7:0]       alarm_vec;
    logic             operational;
    routed = '0;
    alarm_vec = '0;
    operational = 1'b0;
    d = q;
    d.on_ev = 1'b0;
    d.off_ev = 1'b0;
    d.prev_src = src;
    alarm_vec = {1'b0, q.grp_latch | grp_now, port2_down, port1_down, ext_io_inactive, remote_comm_inactive};
    for (int i = 0; i < 8; i++) begin
      if (alarm_vec[i]) begin
        routed = routed | matrix_col[i];
      end
    end
    if (service_link_we) begin
      d.link = service_link_set;
    end
    // latch set wins over a panel clear in the same cycle
    d.grp_latch = (panel_reset ? '0 : q.grp_latch) | grp_now;
    if (|rise) begin
      d.on_ev = 1'b1;
      d.code = first_set(rise);
    end else if (|fall) begin
      d.off_ev = 1'b1;
      d.code = first_set(fall);
    end
    case (q.st)
      ssw_pkg::SSW_BOOT: begin
        if (boot_test_done) begin
          d.st = boot_test_pass ? ssw_pkg::SSW_RUN : ssw_pkg::SSW_PERM;
        end
        d.cnt = '0;
      end
      ssw_pkg::SSW_RUN: begin
        if (mcu_main_fail) begin
          d.st = ssw_pkg::SSW_PERM;
        end else if (mcu_kick) begin
          d.cnt = '0;
          d.tries = '0;
        end else if (q.cnt >= 32'(KICK_TIMEOUT_CYC - 1)) begin
          d.cnt = '0;
          d.st = (q.tries >= 8'(RETRIES)) ? ssw_pkg::SSW_PERM : ssw_pkg::SSW_RESTART;
          d.tries = q.tries + 8'h01;
        end else begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      ssw_pkg::SSW_RESTART: begin
        if (q.cnt >= 32'(RESTART_CYC - 1)) begin
          d.cnt = '0;
          d.st = ssw_pkg::SSW_RUN;
        end else begin
          d.cnt = q.cnt + 32'h1;
        end
      end
      ssw_pkg::SSW_PERM: begin
        d.cnt = '0; // held until reset; rst is the only way out
      end
      default: begin
        d.st = ssw_pkg::SSW_PERM;
      end
    endcase
    operational = (q.st == ssw_pkg::SSW_RUN) & aux_supply_ok & ~(|(q.link & (q.grp_latch | grp_now)));
    d.sf = operational & (d.st == ssw_pkg::SSW_RUN);
    d.dout = (d.st == ssw_pkg::SSW_PERM) ? '0 : (logic_outputs | routed);
    d.w_lo = '0; // reserved bits stay zero
    d.w_lo[`SSW_OUT_LO_CH_LSB +: `SSW_OUT_LO_CH_N] = out_channel_fault[`SSW_OUT_LO_CH_N-1:0];
    d.w_lo[`SSW_OUT_LO_AUX_LSB +: `SSW_OUT_LO_AUX_N] = aux_channel_fault;
    d.w_lo[`SSW_OUT_LO_CH9_BIT] = out_channel_fault[`SSW_OUT_LO_CH9_IDX];
    d.w_hi = '0;
    d.w_hi[`SSW_OUT_HI_N-1:0] = out_channel_fault[`SSW_OUT_HI_IDX0 +: `SSW_OUT_HI_N];
    d.w_pl = '0;
    d.w_pl[`SSW_PLAT_N-1:0] = platform_fault;
    if (rst) begin
      d.st = ssw_pkg::SSW_BOOT;
      d.cnt = '0;
      d.tries = '0;
      d.link = `SSW_LINK_RESET;
      d.grp_latch = '0;
      d.prev_src = '0;
      d.dout = '0;
      d.sf = 1'b0;
      d.on_ev = 1'b0;
      d.off_ev = 1'b0;
      d.code = '0;
      d.w_lo = '0;
      d.w_hi = '0;
      d.w_pl = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign digital_outputs = q.dout;
  assign service_fail_output = q.sf;
  assign mcu_restart = (q.st == ssw_pkg::SSW_RESTART);
  assign permanent_fault = (q.st == ssw_pkg::SSW_PERM);
  assign status_led = (q.st == ssw_pkg::SSW_PERM);
  assign panel_fault_msg = (q.st == ssw_pkg::SSW_PERM);
  assign fault_group = q.grp_latch;
  assign diag_on_event = q.on_ev;
  assign diag_off_event = q.off_ev;
  assign diag_event_code = q.code;
  assign output_fault_status_low = q.w_lo;
  assign output_fault_status_high = q.w_hi;
  assign platform_fault_status = q.w_pl;

  sequence fault_seen_s;
    q.st == ssw_pkg::SSW_PERM;
  endsequence

  block_outputs_a: assert property (@(posedge clk) disable iff (rst) fault_seen_s |=> digital_outputs == '0)
    else $error("outputs not blocked in permanent fault");
  sf_drop_a: assert property (@(posedge clk) disable iff (rst) fault_seen_s |=> !service_fail_output)
    else $error("service output energized in permanent fault");
  sf_supply_a: assert property (@(posedge clk) disable iff (rst) !aux_supply_ok |=> !service_fail_output)
    else $error("service output energized without supply");
  perm_sticky_a: assert property (@(posedge clk) disable iff (rst) permanent_fault |=> permanent_fault)
    else $error("permanent fault released without reset");
  main_fail_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == ssw_pkg::SSW_RUN && mcu_main_fail) |=> permanent_fault)
    else $error("main failure did not enter permanent state");
  restart_end_a: assert property (@(posedge clk) disable iff (rst)
    $rose(mcu_restart) |-> mcu_restart [*1] ##[0:1000] !mcu_restart)
    else $error("restart pulse never ends");
  diag_on_a: assert property (@(posedge clk) disable iff (rst) (|rise) |=> diag_on_event)
    else $error("missing diagnostic-on event");
  diag_off_a: assert property (@(posedge clk) disable iff (rst) (!(|rise) && (|fall)) |=> diag_off_event)
    else $error("missing diagnostic-off event");
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst) output_fault_status_low[1:0] == 2'h0)
    else $error("reserved diagnostic bits set");
  group_latch_a: assert property (@(posedge clk) disable iff (rst) (|grp_now) |=> (|fault_group))
    else $error("group did not follow active member");
endmodule // ssw_watchdog

// ### ssw_regs.svh
/*
  constants for the self-supervision watchdog: diagnostic word layout, timing, defaults.
  assumes inclusion by ssw_pkg.sv and the design module only.
*/
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH
`define SSW_WORD_W          16
`define SSW_SRC_N           10
`define SSW_OUT_N           16
`define SSW_GRP_N           3
`define SSW_OUT_LO_CH_LSB   2
`define SSW_OUT_LO_CH_N     8
`define SSW_OUT_LO_AUX_LSB  10
`define SSW_OUT_LO_AUX_N    5
`define SSW_OUT_LO_CH9_BIT  15
`define SSW_OUT_LO_CH9_IDX  8
`define SSW_OUT_HI_N        15
`define SSW_OUT_HI_IDX0     9
`define SSW_PLAT_N          10
`define SSW_LINK_RESET      3'h2
`define SSW_GRP_RESET       20'h00000
`define SSW_KICK_TIMEOUT_US 100
`define SSW_RESTART_US      10
`define SSW_RETRIES         2
`define SSW_CLK_MHZ         40
`define SSW_IDX_REMOTE      0
`define SSW_IDX_EXT_IO      1
`define SSW_IDX_PORT1       2
`define SSW_IDX_PORT2       3
`define SSW_IDX_GRP0        4
`define SSW_IDX_BOOT_OK     7
`endif

// ### ssw_pkg.sv
/*
  types for the self-supervision watchdog.
  assumes ssw_regs.svh beside it.
*/
`include "ssw_regs.svh"
package ssw_pkg;
  typedef enum logic [3:0] {
    SSW_BOOT    = 4'h1,
    SSW_RUN     = 4'h2,
    SSW_RESTART = 4'h4,
    SSW_PERM    = 4'h8
  } ssw_state_type;
endpackage

// ### ssw_mcu_model.sv
/*
  supervised controller model: sends alive kicks while running.
  assumes clk shared with the watchdog; drives only just after rising edges.
*/
`timescale 1ns/1ps
module ssw_mcu_model #(
  parameter int KICK_GAP = 8
) (
  input  wire logic clk,
  input  wire logic alive,
  input  wire logic restart,
  output logic      kick
);
  int cnt = 0;
  initial kick = 1'b0;
  // a restart halts the program; kicks come back only once alive says it recovered
  always @(posedge clk) begin
    cnt <= (cnt + 1) % KICK_GAP;
    kick <= alive && !restart && cnt == 0;
  end
endmodule // ssw_mcu_model

// ### self_supervision_watchdog_tb.sv
/*
  self-checking bench for ssw_watchdog: words, routing, groups, service output, supervision.
  assumes a short kick timeout so a full fault escalation fits in a short run.
*/
`timescale 1ns/1ps
module self_supervision_watchdog_tb;
  localparam int KT = 20;
  localparam int RC = 4;
  localparam int RT = 1;
  logic        clk = 1'b0, rst = 1'b1, alive = 1'b0, kick, main_fail = 1'b0;
  logic        bt_done = 1'b0, bt_pass = 1'b0, aux_ok = 1'b1, panel_rst = 1'b0, link_we = 1'b0;
  logic [3:0]  alarm = 4'h0;
  logic [23:0] ocf = 24'h0;
  logic [4:0]  acf = 5'h0;
  logic [9:0]  pf = 10'h0;
  logic [19:0] gsel = 20'hfffff;
  logic [2:0]  link = 3'h2, grp;
  logic [15:0] mcol [8];
  logic [15:0] lo_req = 16'h0, dout, w_lo, w_hi, w_pl;
  logic        sf, restart, perm, led, pmsg, on_ev, off_ev;
  int          failures = 0, compares = 0, on_cnt = 0, off_cnt = 0, i, on0, off0;
  logic [3:0]  code, exp_code = 4'h0;
  logic [9:0]  pf_prev;

  ssw_mcu_model #(.KICK_GAP(8)) i_mcu (.clk(clk), .alive(alive), .restart(restart), .kick(kick));
  ssw_watchdog #(.KICK_TIMEOUT_CYC(KT), .RESTART_CYC(RC), .RETRIES(RT), .OUT_N(16)) i_dut (
    .clk(clk), .rst(rst), .mcu_kick(kick), .mcu_main_fail(main_fail),
    .boot_test_done(bt_done), .boot_test_pass(bt_pass), .aux_supply_ok(aux_ok),
    .panel_reset(panel_rst), .remote_comm_inactive(alarm[0]), .ext_io_inactive(alarm[1]),
    .port1_down(alarm[2]), .port2_down(alarm[3]), .out_channel_fault(ocf),
    .aux_channel_fault(acf), .platform_fault(pf), .group_select(gsel),
    .service_link_set(link), .service_link_we(link_we), .matrix_col(mcol),
    .logic_outputs(lo_req), .digital_outputs(dout), .service_fail_output(sf),
    .mcu_restart(restart), .permanent_fault(perm), .status_led(led), .panel_fault_msg(pmsg),
    .fault_group(grp), .diag_on_event(on_ev), .diag_off_event(off_ev), .diag_event_code(code),
    .output_fault_status_low(w_lo), .output_fault_status_high(w_hi), .platform_fault_status(w_pl));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (on_ev === 1'b1) on_cnt++;
    if (off_ev === 1'b1) off_cnt++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // which 0 waits for a restart pulse, 1 for the permanent fault
  task automatic wait_for(input int which, input int bound);
    for (i = 0; i < bound; i++) begin
      @(negedge clk);
      if ((which == 0 && restart === 1'b1) || (which == 1 && perm === 1'b1)) return;
    end
    failures++;
    $display("FAIL at %0t: wait %h bound %h ran out", $time, which, bound);
    print_verdict;
  endtask
  task automatic boot(input logic pass);
    @(posedge clk);
    rst <= 1'b1;
    bt_done <= 1'b0;
    cyc(12);
    rst <= 1'b0;
    bt_done <= 1'b1;
    bt_pass <= pass;
    alive <= 1'b1;
    cyc(3);
  endtask
  // bench model of the output matrix: requests or every active alarm column
  function automatic logic [15:0] route(input logic [6:0] act);
    route = lo_req;
    for (int k = 0; k < 7; k++) if (act[k]) route |= mcol[k];
  endfunction
  // lowest changed source index, the short code an event carries
  function automatic logic [3:0] low_bit(input logic [9:0] v);
    low_bit = 4'h0;
    for (int k = 9; k >= 0; k--) if (v[k]) low_bit = 4'(k);
  endfunction
  task automatic pulse_settle;
    cyc(3);
    @(negedge clk);
  endtask

  initial begin
    foreach (mcol[k]) mcol[k] = 16'h0;
    void'($urandom(32'hb014));
    boot(1'b1);
    @(negedge clk);
    chk(sf, 1);
    chk(perm, 0);
    $display("boot test done");
    repeat (8) begin
      @(posedge clk);
      pf_prev = pf;
      ocf <= 24'($urandom);
      acf <= 5'($urandom);
      pf <= 10'($urandom);
      lo_req <= 16'($urandom);
      alarm <= 4'($urandom);
      foreach (mcol[k]) mcol[k] <= 16'($urandom);
      pulse_settle();
      chk(w_lo, {ocf[8], acf, ocf[7:0], 2'b00});
      chk(w_hi, {1'b0, ocf[23:9]});
      chk(w_pl, {6'h0, pf});
      chk(dout, route({3'b000, alarm}));
      // rising sources take priority over falling ones in the same cycle
      if (|(pf & ~pf_prev)) exp_code = low_bit(pf & ~pf_prev);
      else if (|(pf_prev & ~pf)) exp_code = low_bit(pf_prev & ~pf);
      chk(code, exp_code);
    end
    $display("word and routing test done");
    @(posedge clk);
    alarm <= 4'h0;
    pf <= 10'h0;
    gsel <= {18'h3ffff, 2'h0};
    pulse_settle();
    on0 = on_cnt;
    off0 = off_cnt;
    @(posedge clk);
    pf <= 10'h001;
    pulse_settle();
    chk(on_cnt - on0, 1);
    chk(grp, 3'b001);
    chk(dout, route(7'b0010000));
    chk(sf, 1);
    @(posedge clk);
    pf <= 10'h000;
    pulse_settle();
    chk(off_cnt - off0, 1);
    @(posedge clk);
    link <= 3'b001;
    link_we <= 1'b1;
    @(posedge clk);
    link_we <= 1'b0;
    pulse_settle();
    chk(sf, 0);
    @(posedge clk);
    panel_rst <= 1'b1;
    @(posedge clk);
    panel_rst <= 1'b0;
    pulse_settle();
    chk(grp, 0);
    chk(sf, 1);
    @(posedge clk);
    aux_ok <= 1'b0;
    pulse_settle();
    chk(sf, 0);
    chk(restart, 0);
    @(posedge clk);
    aux_ok <= 1'b1;
    lo_req <= 16'hffff;
    alive <= 1'b0;
    $display("group test done");
    wait_for(0, KT + 10);
    chk(perm, 0);
    @(posedge clk);
    alive <= 1'b1;
    cyc(RC + 2 * KT);
    @(negedge clk);
    chk(perm, 0);
    @(posedge clk);
    alive <= 1'b0;
    wait_for(1, (RT + 1) * (KT + RC) + 20);
    @(negedge clk);
    chk(dout, 0);
    chk({sf, led, pmsg}, 3'b011);
    boot(1'b1);
    main_fail <= 1'b1;
    wait_for(1, 10);
    chk(dout, 0);
    @(posedge clk);
    main_fail <= 1'b0;
    boot(1'b0);
    wait_for(1, 10);
    chk(sf, 0);
    $display("supervision test done");
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule // self_supervision_watchdog_tb
